// >>> rtl/csfg_defines.svh
// Purpose: constants of the cpu status flag generator
// Assumes: included by bare name from the top
// Notes: times in their own unit, counts derived from the clock rate
`ifndef CSFG_DEFINES_SVH
`define CSFG_DEFINES_SVH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define CSFG_REG_FLAGS_LO 4'h0
`define CSFG_REG_FLAGS_HI 4'h1
`define CSFG_REG_SYNTAX 4'h2
`define CSFG_REG_CTRL 4'h3
`define CSFG_REG_CLEAR 4'h4

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CSFG_CTRL_CFG_CHECK 0
`define CSFG_CTRL_WDOG_EN 1
`define CSFG_CTRL_RESET 2'h3
`define CSFG_CLR_CRIT 0
`define CSFG_CLR_WARN 1
`define CSFG_CLR_CFG 2
`define CSFG_CLR_WDOG 3
`define CSFG_CLR_SYNTAX 4
`define CSFG_CLR_SLOT 5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CSFG_CLK_HZ 25000000
`define CSFG_TICK_MS 1
`define CSFG_MS_CYCLES (`CSFG_CLK_HZ / 1000 * `CSFG_TICK_MS)
`define CSFG_MINUTE_HALF_MS 30000
`define CSFG_SECOND_HALF_MS 500
`define CSFG_TENTH_HALF_MS 50
`define CSFG_TWENTIETH_HALF_MS 25
`define CSFG_WDOG_MS 200

`endif

// >>> rtl/csfg_pkg.sv
// Purpose: types of the cpu status flag generator
// Assumes: nothing beyond the defines header
// Notes: flags_t is the packed order of the status read words
package csfg_pkg;

  // ----------------------------------------------------------------
  // modes and operations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SW_STOP, SW_TERM, SW_RUN} csfg_sw_t;
  typedef enum logic [2:0] {
    MD_PROGRAM, MD_RUN, MD_TEST_RUN, MD_TEST_HOLD, MD_TEST_PROGRAM
  } csfg_mode_t;
  typedef enum logic [2:0] {
    OP_CMP, OP_ADD16, OP_SUB16, OP_ADD32, OP_SUB32, OP_LOAD
  } csfg_op_t;

  // ----------------------------------------------------------------
  // flag vector, 50 bits, first field is bit 49
  // ----------------------------------------------------------------
  typedef struct packed {
    logic first_scan_flag;
    logic constant_true_flag;
    logic constant_false_flag;
    logic minute_square_wave;
    logic second_square_wave;
    logic tenth_second_square_wave;
    logic twentieth_second_square_wave;
    logic alternate_scan_flag;
    logic switch_run_flag;
    logic terminal_run_flag;
    logic test_run_flag;
    logic test_hold_flag;
    logic test_program_flag;
    logic terminal_program_flag;
    logic switch_stop_flag;
    logic instruction_stop_flag;
    logic break_flag;
    logic interrupt_enabled_flag;
    logic critical_error_flag;
    logic warning_flag;
    logic io_config_error_flag;
    logic watchdog_expired_flag;
    logic syntax_error_flag;
    logic less_than_flag;
    logic equal_flag;
    logic greater_than_flag;
    logic zero_result_flag;
    logic borrow16_flag;
    logic borrow32_flag;
    logic carry16_flag;
    logic carry32_flag;
    logic negative_flag;
    logic signed_overflow_flag;
    logic loaded_zero_flag;
    logic [7:0] slot_busy_flag;
    logic [7:0] slot_comm_error_flag;
  } csfg_flags_t;

  // ----------------------------------------------------------------
  // whole state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    csfg_flags_t f;
    logic [14:0] ms_cnt_reg;
    logic [3:0][15:0] wave_cnt_reg;
    logic first_pend_reg;
    csfg_mode_t prev_mode_reg;
    logic [1:0] ctrl_reg;
    logic [15:0] wdog_cnt_reg;
    logic [15:0] syntax_code_reg;
    logic [31:0] rdata_reg;
  } csfg_state_t;

endpackage

// >>> rtl/csfg_top.sv
// Purpose: status flags of the controller cpu for program and executor
// Assumes: all inputs synchronous to CLK, event inputs one cycle pulses
// Notes: flags come straight from flip-flops
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "csfg_defines.svh"

module csfg_top #(
  parameter int MS_CYCLES = `CSFG_MS_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // scan and mode
  input wire logic SCAN_START,
  input wire csfg_pkg::csfg_sw_t SWITCH_POS,
  input wire csfg_pkg::csfg_mode_t OP_MODE,
  // instruction events
  input wire logic STOP_EXEC,
  input wire logic BREAK_EXEC,
  input wire logic ENI_EXEC,
  input wire logic DISI_EXEC,
  input wire logic WDOG_KICK,
  // fault events
  input wire logic CRIT_FAULT,
  input wire logic WARN_FAULT,
  input wire logic CFG_MISMATCH,
  input wire logic SYNTAX_ERR,
  input wire logic [15:0] SYNTAX_CODE,
  // accumulator operation
  input wire logic ACC_VALID,
  input wire csfg_pkg::csfg_op_t ACC_OP,
  input wire logic [31:0] ACC_A,
  input wire logic [31:0] ACC_B,
  // slot modules
  input wire logic [7:0] SLOT_BUSY,
  input wire logic [7:0] SLOT_ERR,
  // flags out
  output csfg_pkg::csfg_flags_t FLAGS,
  output logic [15:0] SYNTAX_CODE_WORD
);

  // ----------------------------------------------------------------
  // constants and state
  // ----------------------------------------------------------------
  localparam logic [3:0][15:0] WAVE_HALF = {
    16'(`CSFG_TWENTIETH_HALF_MS), 16'(`CSFG_TENTH_HALF_MS),
    16'(`CSFG_SECOND_HALF_MS), 16'(`CSFG_MINUTE_HALF_MS)};
  localparam logic [15:0] WDOG_LIMIT = 16'(`CSFG_WDOG_MS);

  csfg_pkg::csfg_state_t s_reg;
  csfg_pkg::csfg_state_t s_next;
  logic tick;
  logic run_entry;

  // millisecond tick from the clock divider
  assign tick = (s_reg.ms_cnt_reg == 15'(MS_CYCLES - 1));
  // mode change into run
  assign run_entry = (OP_MODE == csfg_pkg::MD_RUN) &&
                     (s_reg.prev_mode_reg != csfg_pkg::MD_RUN);

  // outputs straight from flops
  assign FLAGS = s_reg.f;
  assign SYNTAX_CODE_WORD = s_reg.syntax_code_reg;
  assign RDATA = s_reg.rdata_reg;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] wv;
    logic [5:0] clr;
    logic [32:0] s33;
    logic [32:0] d33;
    logic [16:0] s17;
    logic [16:0] d17;
    logic [31:0] res;
    logic wr_acc;
    logic sgn;
    wv = {s_reg.f.twentieth_second_square_wave,
          s_reg.f.tenth_second_square_wave,
          s_reg.f.second_square_wave,
          s_reg.f.minute_square_wave};
    clr = '0;
    s33 = {1'b0, ACC_A} + {1'b0, ACC_B};
    d33 = {1'b0, ACC_A} - {1'b0, ACC_B};
    s17 = {1'b0, ACC_A[15:0]} + {1'b0, ACC_B[15:0]};
    d17 = {1'b0, ACC_A[15:0]} - {1'b0, ACC_B[15:0]};
    res = '0;
    wr_acc = 1'b0;
    sgn = 1'b0;
    s_next = s_reg;

    // constant contacts
    s_next.f.constant_true_flag = 1'b1;
    s_next.f.constant_false_flag = 1'b0;

    // timebase and square waves
    s_next.ms_cnt_reg = tick ? 15'h0000 : s_reg.ms_cnt_reg + 15'h0001;
    for (int i = 0; i < 4; i++) begin
      if (tick) begin
        if (s_reg.wave_cnt_reg[i] == WAVE_HALF[i] - 16'h0001) begin
          s_next.wave_cnt_reg[i] = 16'h0000;
          wv[i] = ~wv[i];
        end else begin
          s_next.wave_cnt_reg[i] = s_reg.wave_cnt_reg[i] + 16'h0001;
        end
      end
    end
    s_next.f.minute_square_wave = wv[0];
    s_next.f.second_square_wave = wv[1];
    s_next.f.tenth_second_square_wave = wv[2];
    s_next.f.twentieth_second_square_wave = wv[3];

    // scan flags, a pending entry arms the next scan
    s_next.prev_mode_reg = OP_MODE;
    if (SCAN_START) begin
      s_next.f.first_scan_flag = s_reg.first_pend_reg;
      s_next.first_pend_reg = 1'b0;
      s_next.f.alternate_scan_flag = ~s_reg.f.alternate_scan_flag;
    end
    if (run_entry) begin
      s_next.first_pend_reg = 1'b1;
    end

    // switch and mode flags
    s_next.f.switch_run_flag = (SWITCH_POS == csfg_pkg::SW_RUN);
    s_next.f.switch_stop_flag = (SWITCH_POS == csfg_pkg::SW_STOP);
    s_next.f.terminal_run_flag = 1'b0;
    s_next.f.test_run_flag = 1'b0;
    s_next.f.test_hold_flag = 1'b0;
    s_next.f.test_program_flag = 1'b0;
    s_next.f.terminal_program_flag = 1'b0;
    if (SWITCH_POS == csfg_pkg::SW_TERM) begin
      unique case (OP_MODE)
        csfg_pkg::MD_RUN: s_next.f.terminal_run_flag = 1'b1;
        csfg_pkg::MD_TEST_RUN: s_next.f.test_run_flag = 1'b1;
        csfg_pkg::MD_TEST_HOLD: s_next.f.test_hold_flag = 1'b1;
        csfg_pkg::MD_TEST_PROGRAM: s_next.f.test_program_flag = 1'b1;
        csfg_pkg::MD_PROGRAM: s_next.f.terminal_program_flag = 1'b1;
        default: ;
      endcase
    end

    // instruction flags, set wins over the clear
    if (run_entry) begin
      s_next.f.break_flag = 1'b0;
      s_next.f.instruction_stop_flag = 1'b0;
    end
    if (STOP_EXEC) begin
      s_next.f.instruction_stop_flag = 1'b1;
    end
    if (BREAK_EXEC) begin
      s_next.f.break_flag = 1'b1;
    end
    if (DISI_EXEC) begin
      s_next.f.interrupt_enabled_flag = 1'b0;
    end
    if (ENI_EXEC) begin
      s_next.f.interrupt_enabled_flag = 1'b1;
    end

    // register writes
    if (WR && ADDR == `CSFG_REG_CTRL) begin
      s_next.ctrl_reg = WDATA[1:0];
    end
    if (WR && ADDR == `CSFG_REG_CLEAR) begin
      clr = WDATA[5:0];
    end

    // sticky faults, clear first so a new event wins
    if (clr[`CSFG_CLR_CRIT]) begin
      s_next.f.critical_error_flag = 1'b0;
    end
    if (clr[`CSFG_CLR_WARN]) begin
      s_next.f.warning_flag = 1'b0;
    end
    if (clr[`CSFG_CLR_CFG]) begin
      s_next.f.io_config_error_flag = 1'b0;
    end
    if (clr[`CSFG_CLR_WDOG]) begin
      s_next.f.watchdog_expired_flag = 1'b0;
    end
    if (clr[`CSFG_CLR_SYNTAX]) begin
      s_next.f.syntax_error_flag = 1'b0;
    end
    if (CRIT_FAULT) begin
      s_next.f.critical_error_flag = 1'b1;
    end
    if (WARN_FAULT) begin
      s_next.f.warning_flag = 1'b1;
    end
    if (CFG_MISMATCH && s_reg.ctrl_reg[`CSFG_CTRL_CFG_CHECK]) begin
      s_next.f.io_config_error_flag = 1'b1;
    end
    if (SYNTAX_ERR) begin
      s_next.f.syntax_error_flag = 1'b1;
      s_next.syntax_code_reg = SYNTAX_CODE;
    end

    // watchdog counts ticks between kicks, holds when run out
    if (WDOG_KICK || !s_reg.ctrl_reg[`CSFG_CTRL_WDOG_EN]) begin
      s_next.wdog_cnt_reg = 16'h0000;
    end else if (tick) begin
      if (s_reg.wdog_cnt_reg == WDOG_LIMIT - 16'h0001) begin
        s_next.f.watchdog_expired_flag = 1'b1;
      end else begin
        s_next.wdog_cnt_reg = s_reg.wdog_cnt_reg + 16'h0001;
      end
    end

    // accumulator flags
    if (ACC_VALID) begin
      unique case (ACC_OP)
        csfg_pkg::OP_CMP: begin
          s_next.f.less_than_flag = (ACC_A < ACC_B);
          s_next.f.equal_flag = (ACC_A == ACC_B);
          s_next.f.greater_than_flag = (ACC_A > ACC_B);
        end
        csfg_pkg::OP_ADD16: begin
          res = {16'h0000, s17[15:0]};
          wr_acc = 1'b1;
          sgn = s17[15];
          s_next.f.carry16_flag = s17[16];
          s_next.f.signed_overflow_flag = (ACC_A[15] == ACC_B[15]) &&
                                          (s17[15] != ACC_A[15]);
        end
        csfg_pkg::OP_SUB16: begin
          res = {16'h0000, d17[15:0]};
          wr_acc = 1'b1;
          sgn = d17[15];
          s_next.f.borrow16_flag = d17[16];
          s_next.f.signed_overflow_flag = (ACC_A[15] != ACC_B[15]) &&
                                          (d17[15] != ACC_A[15]);
        end
        csfg_pkg::OP_ADD32: begin
          res = s33[31:0];
          wr_acc = 1'b1;
          sgn = s33[31];
          s_next.f.carry32_flag = s33[32];
          s_next.f.signed_overflow_flag = (ACC_A[31] == ACC_B[31]) &&
                                          (s33[31] != ACC_A[31]);
        end
        csfg_pkg::OP_SUB32: begin
          res = d33[31:0];
          wr_acc = 1'b1;
          sgn = d33[31];
          s_next.f.borrow32_flag = d33[32];
          s_next.f.signed_overflow_flag = (ACC_A[31] != ACC_B[31]) &&
                                          (d33[31] != ACC_A[31]);
        end
        csfg_pkg::OP_LOAD: begin
          res = ACC_B;
          wr_acc = 1'b1;
          sgn = ACC_B[31];
          s_next.f.loaded_zero_flag = (ACC_B == 32'h0000_0000);
        end
        default: ;
      endcase
    end
    if (wr_acc) begin
      s_next.f.zero_result_flag = (res == 32'h0000_0000);
      s_next.f.negative_flag = sgn;
    end

    // slot modules, error sticky with set winning
    s_next.f.slot_busy_flag = SLOT_BUSY;
    s_next.f.slot_comm_error_flag = (s_reg.f.slot_comm_error_flag &
      ~{8{clr[`CSFG_CLR_SLOT]}}) | SLOT_ERR;

    // read data for one cycle only
    s_next.rdata_reg = 32'h0000_0000;
    if (RD) begin
      unique case (ADDR)
        `CSFG_REG_FLAGS_LO: s_next.rdata_reg = s_reg.f[31:0];
        `CSFG_REG_FLAGS_HI: s_next.rdata_reg = {14'h0000, s_reg.f[49:32]};
        `CSFG_REG_SYNTAX: s_next.rdata_reg = {16'h0000,
                                              s_reg.syntax_code_reg};
        `CSFG_REG_CTRL: s_next.rdata_reg = {30'h0000_0000, s_reg.ctrl_reg};
        default: s_next.rdata_reg = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s_reg <= '0;
      s_reg.f.constant_true_flag <= 1'b1;
      s_reg.first_pend_reg <= 1'b1;
      s_reg.ctrl_reg <= `CSFG_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  property p_first;
    FLAGS.first_scan_flag && SCAN_START && !run_entry &&
      !s_reg.first_pend_reg |=> !FLAGS.first_scan_flag [*2];
  endproperty
  a_first: assert property (p_first)
    else $error("first scan flag outlived its scan");

  property p_const;
    FLAGS.constant_true_flag && !FLAGS.constant_false_flag;
  endproperty
  a_const: assert property (p_const)
    else $error("constant flags wrong");

  property p_min;
    $changed(FLAGS.minute_square_wave)
      |-> $past(s_reg.wave_cnt_reg[0]) == WAVE_HALF[0] - 16'h0001 &&
          $past(tick);
  endproperty
  a_min: assert property (p_min)
    else $error("minute wave toggled early");

  property p_sec;
    $changed(FLAGS.second_square_wave)
      |-> $past(s_reg.wave_cnt_reg[1]) == WAVE_HALF[1] - 16'h0001 &&
          $past(tick);
  endproperty
  a_sec: assert property (p_sec)
    else $error("second wave toggled early");

  property p_tenth;
    $changed(FLAGS.tenth_second_square_wave)
      |-> $past(s_reg.wave_cnt_reg[2]) == WAVE_HALF[2] - 16'h0001 &&
          $past(tick);
  endproperty
  a_tenth: assert property (p_tenth)
    else $error("tenth wave toggled early");

  property p_twen;
    $changed(FLAGS.twentieth_second_square_wave)
      |-> $past(s_reg.wave_cnt_reg[3]) == WAVE_HALF[3] - 16'h0001 &&
          $past(tick);
  endproperty
  a_twen: assert property (p_twen)
    else $error("twentieth wave toggled early");

  property p_swrun;
    RSTN && SWITCH_POS == csfg_pkg::SW_RUN |=> FLAGS.switch_run_flag;
  endproperty
  a_swrun: assert property (p_swrun)
    else $error("switch run flag missing");

  property p_term;
    RSTN && SWITCH_POS == csfg_pkg::SW_TERM |=> $onehot({
      FLAGS.terminal_run_flag,
      FLAGS.test_run_flag, FLAGS.test_hold_flag, FLAGS.test_program_flag,
      FLAGS.terminal_program_flag});
  endproperty
  a_term: assert property (p_term)
    else $error("terminal mode flags not one hot");

  property p_brk;
    BREAK_EXEC |=> FLAGS.break_flag;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break flag not set");

  property p_cfg;
    $rose(FLAGS.io_config_error_flag)
      |-> $past(s_reg.ctrl_reg[`CSFG_CTRL_CFG_CHECK]) && $past(CFG_MISMATCH);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config error without enabled check");

  property p_syn;
    SYNTAX_ERR |=> FLAGS.syntax_error_flag &&
      SYNTAX_CODE_WORD == $past(SYNTAX_CODE);
  endproperty
  a_syn: assert property (p_syn)
    else $error("syntax code not stored");

  property p_cmp;
    ACC_VALID && ACC_OP == csfg_pkg::OP_CMP |=> $onehot({
      FLAGS.less_than_flag, FLAGS.equal_flag, FLAGS.greater_than_flag});
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare flags not one hot");

  c_first: cover property (SCAN_START ##1 FLAGS.first_scan_flag);
  c_wdog: cover property ($rose(FLAGS.watchdog_expired_flag));
  c_sec: cover property ($fell(FLAGS.second_square_wave));

endmodule
`default_nettype wire

// >>> tb/csfg_tb.sv
// Purpose: self-checking bench for the cpu status flag generator
// Assumes: MS_CYCLES shortened to 2, so one ms tick is two clocks
// Notes: table rows for mode and accumulator, a reset test before them, hand tests after them
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // signals and table types
  // ----------------------------------------------------------------
  localparam int MSC = 2;
  typedef struct packed {
    csfg_pkg::csfg_sw_t sw;
    csfg_pkg::csfg_mode_t md;
    csfg_pkg::csfg_op_t op;
    logic [31:0] a;
    logic [31:0] b;
    logic [6:0] em;
    logic [10:0] ea;
  } csfg_row_t;
  logic CLK, RSTN, WR, RD;
  logic [3:0] ADDR;
  logic [31:0] WDATA, RDATA, ACC_A, ACC_B, r;
  logic [10:0] ev;
  logic [15:0] SYNTAX_CODE, SYNTAX_CODE_WORD;
  logic [7:0] SLOT_BUSY, SLOT_ERR;
  csfg_pkg::csfg_sw_t SWITCH_POS;
  csfg_pkg::csfg_mode_t OP_MODE;
  csfg_pkg::csfg_op_t ACC_OP;
  csfg_pkg::csfg_flags_t FLAGS;
  int fails, check_count, cyc;
  logic [10:0] msk [6] = '{11'h700, 11'h096, 11'h0C6, 11'h08E, 11'h0A6,
    11'h085};
  csfg_row_t rows [12] = '{
    '{csfg_pkg::SW_RUN, csfg_pkg::MD_RUN, csfg_pkg::OP_CMP,
      32'h0000_0005, 32'h0000_0009, 7'h40, 11'h400},
    '{csfg_pkg::SW_STOP, csfg_pkg::MD_PROGRAM, csfg_pkg::OP_CMP,
      32'h0000_0009, 32'h0000_0009, 7'h01, 11'h200},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_RUN, csfg_pkg::OP_CMP,
      32'hFFFF_FFFF, 32'h0000_0001, 7'h20, 11'h100},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_TEST_RUN, csfg_pkg::OP_ADD16,
      32'h0000_FFFF, 32'h0000_0001, 7'h10, 11'h090},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_TEST_HOLD, csfg_pkg::OP_ADD16,
      32'h0000_7FFF, 32'h0000_0001, 7'h08, 11'h006},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_TEST_PROGRAM, csfg_pkg::OP_SUB16,
      32'h0000_0003, 32'h0000_0005, 7'h04, 11'h044},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_PROGRAM, csfg_pkg::OP_SUB16,
      32'h0000_8000, 32'h0000_0001, 7'h02, 11'h002},
    '{csfg_pkg::SW_RUN, csfg_pkg::MD_PROGRAM, csfg_pkg::OP_ADD32,
      32'hFFFF_FFFF, 32'h0000_0001, 7'h40, 11'h088},
    '{csfg_pkg::SW_STOP, csfg_pkg::MD_RUN, csfg_pkg::OP_SUB32,
      32'h0000_0000, 32'h0000_0001, 7'h01, 11'h024},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_RUN, csfg_pkg::OP_ADD32,
      32'h7FFF_FFFF, 32'h0000_0001, 7'h20, 11'h006},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_TEST_HOLD, csfg_pkg::OP_LOAD,
      32'h0000_0001, 32'h0000_0000, 7'h08, 11'h081},
    '{csfg_pkg::SW_TERM, csfg_pkg::MD_PROGRAM, csfg_pkg::OP_LOAD,
      32'h0000_0000, 32'h8000_8000, 7'h02, 11'h004}};

  // ----------------------------------------------------------------
  // device under test
  // ----------------------------------------------------------------
  csfg_top #(.MS_CYCLES(MSC)) i_dut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SCAN_START(ev[0]), .SWITCH_POS(SWITCH_POS), .OP_MODE(OP_MODE),
    .STOP_EXEC(ev[1]), .BREAK_EXEC(ev[2]), .ENI_EXEC(ev[3]),
    .DISI_EXEC(ev[4]), .WDOG_KICK(ev[5]), .CRIT_FAULT(ev[6]),
    .WARN_FAULT(ev[7]), .CFG_MISMATCH(ev[8]), .SYNTAX_ERR(ev[9]),
    .SYNTAX_CODE(SYNTAX_CODE), .ACC_VALID(ev[10]), .ACC_OP(ACC_OP),
    .ACC_A(ACC_A), .ACC_B(ACC_B), .SLOT_BUSY(SLOT_BUSY),
    .SLOT_ERR(SLOT_ERR), .FLAGS(FLAGS),
    .SYNTAX_CODE_WORD(SYNTAX_CODE_WORD));

  // ----------------------------------------------------------------
  // clock, cycle count since release, watchdog
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  always @(posedge CLK) cyc <= RSTN ? cyc + 1 : 0;
  initial begin
    #3000000;
    fails++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge CLK) ev <= m;
    @(posedge CLK) ev <= 11'h000;
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK) begin
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
    end
    @(posedge CLK) WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLK) begin
      ADDR <= a;
      RD <= 1'b1;
    end
    @(posedge CLK) RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic setm(input csfg_pkg::csfg_sw_t s,
      input csfg_pkg::csfg_mode_t m);
    @(posedge CLK) begin
      SWITCH_POS <= s;
      OP_MODE <= m;
    end
    @(posedge CLK) #1;
  endtask
  task automatic hp(input int k, input int exp);
    int n;
    n = 0;
    while (FLAGS[k] !== 1'b0 && n < 5000) begin
      @(posedge CLK) #1;
      n++;
    end
    while (FLAGS[k] !== 1'b1 && n < 5000) begin
      @(posedge CLK) #1;
      n++;
    end
    n = 0;
    while (FLAGS[k] === 1'b1 && n < 5000) begin
      @(posedge CLK) #1;
      n++;
    end
    chk(64'(n), 64'(exp));
  endtask
  task automatic finish_test();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    RSTN = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 4'h0; WDATA = 32'h0;
    ev = 11'h000; SYNTAX_CODE = 16'h0; SLOT_BUSY = 8'h00;
    SLOT_ERR = 8'h00; ACC_A = 32'h0; ACC_B = 32'h0;
    ACC_OP = csfg_pkg::OP_CMP; SWITCH_POS = csfg_pkg::SW_TERM;
    OP_MODE = csfg_pkg::MD_PROGRAM; fails = 0; check_count = 0;
    repeat (5) @(posedge CLK);
    #1 chk({14'h0, FLAGS}, 64'h0001_0000_0000_0000);
    @(posedge CLK) RSTN <= 1'b1;
    rd(4'h3, r);
    chk(r, 32'h0000_0003);
    rd(4'hF, r);
    chk(r, 32'h0000_0000);
    wr(4'h3, 32'h0000_0001);
    pulse(11'h001);
    chk({FLAGS[49], FLAGS[42]}, 2'b11);
    rd(4'h1, r);
    chk(r, 32'h0003_0410);
    pulse(11'h001);
    chk({FLAGS[49], FLAGS[42]}, 2'b00);
    $display("test reset_scan done");
    // table rows: mode flags and accumulator flags
    foreach (rows[i]) begin
      @(posedge CLK) begin
        SWITCH_POS <= rows[i].sw;
        OP_MODE <= rows[i].md;
        ACC_OP <= rows[i].op;
        ACC_A <= rows[i].a;
        ACC_B <= rows[i].b;
        ev <= 11'h400;
      end
      @(posedge CLK) ev <= 11'h000;
      @(posedge CLK) #1;
      chk(FLAGS[41:35], rows[i].em);
      chk(FLAGS[26:16] & msk[rows[i].op], rows[i].ea);
    end
    $display("test table done");
    // instruction events and run entry
    pulse(11'h00E);
    chk(FLAGS[34:32], 3'b111);
    pulse(11'h010);
    chk(FLAGS[34:32], 3'b110);
    setm(csfg_pkg::SW_TERM, csfg_pkg::MD_RUN);
    chk(FLAGS[34:32], 3'b000);
    pulse(11'h001);
    chk(FLAGS[49], 1'b1);
    pulse(11'h001);
    chk(FLAGS[49], 1'b0);
    // fault flags, check enable and clear
    pulse(11'h1C0);
    chk(FLAGS[31:29], 3'b111);
    wr(4'h4, 32'h0000_0007);
    chk(FLAGS[31:29], 3'b000);
    wr(4'h3, 32'h0000_0000);
    pulse(11'h100);
    chk(FLAGS[29], 1'b0);
    wr(4'h3, 32'h0000_0001);
    @(posedge CLK) SYNTAX_CODE <= 16'hBEEF;
    pulse(11'h200);
    chk({FLAGS[27], SYNTAX_CODE_WORD}, 17'h1_BEEF);
    rd(4'h2, r);
    chk(r, 32'h0000_BEEF);
    wr(4'h4, 32'h0000_0010);
    chk(FLAGS[27], 1'b0);
    // slots
    @(posedge CLK) begin
      SLOT_BUSY <= 8'hA5;
      SLOT_ERR <= 8'h3C;
    end
    @(posedge CLK) SLOT_ERR <= 8'h00;
    rd(4'h0, r);
    chk(r[15:0], 16'hA53C);
    // slot 0 busy flag follows bit 0 of SLOT_BUSY
    chk(FLAGS[8], 1'b1);
    wr(4'h4, 32'h0000_0020);
    @(posedge CLK) SLOT_BUSY <= 8'h00;
    @(posedge CLK) #1;
    chk(FLAGS[15:0], 16'h0000);
    $display("test events done");
    // watchdog 200 ticks after the last kick
    wr(4'h3, 32'h0000_0003);
    pulse(11'h020);
    repeat (390) @(posedge CLK);
    #1 chk(FLAGS[28], 1'b0);
    repeat (20) @(posedge CLK);
    #1 chk(FLAGS[28], 1'b1);
    wr(4'h3, 32'h0000_0001);
    wr(4'h4, 32'h0000_0008);
    chk(FLAGS[28], 1'b0);
    $display("test watchdog done");
    // square waves, high phases in clocks
    hp(43, 25 * MSC);
    hp(44, 50 * MSC);
    hp(45, 500 * MSC);
    wait (cyc >= 59980);
    #1 chk(FLAGS[46], 1'b0);
    wait (cyc >= 60020);
    #1 chk(FLAGS[46], 1'b1);
    $display("test waves done");
    // mid-run reset outside run mode: only the reset arms the first scan
    setm(csfg_pkg::SW_TERM, csfg_pkg::MD_PROGRAM);
    @(posedge CLK) RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk({14'h0, FLAGS}, 64'h0001_0000_0000_0000);
    @(posedge CLK) RSTN <= 1'b1;
    rd(4'h3, r);
    chk(r, 32'h0000_0003);
    pulse(11'h001);
    chk(FLAGS[49], 1'b1);
    $display("test mid reset done");
    finish_test();
  end
endmodule

`default_nettype wire
